// ---- common/drv_ctrl_one_pkg.sv ----
// Purpose: constants and types for the second control/status word block
// Assumes: 16-bit serial frames, system clock at 10 MHz
// Notes: driver index 0..7 = output_one low, output_one high, output_two low, output_two high,
//        output_three low, output_three high, output_four high, output_five high
package drv_ctrl_one_pkg;
   // ***********************************************************
   // frame layout
   // ***********************************************************
   localparam int WORD_W = 16;
   localparam int DRIVER_N = 8;
   localparam int OUTPUT_N = 5;
   localparam int SEL_BIT = 0;
   localparam int GATE_LO = 1;
   localparam int RETRY_LO = 6;
   localparam int DUTY_BIT = 13;
   localparam int OL_IGNORE_BIT = 14;
   localparam int NO_ERROR_BIT = 0;
   localparam int OPEN_LO = 1;
   localparam int UNUSED_BIT = 9;
   localparam int NOT_READY_BIT = 10;
   localparam int ALWAYS_ONE_BIT = 15;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLOCK_HZ = 10_000_000;
   localparam int OL_FILTER_MS = 1;
   localparam int OL_FILTER_CYCLES = (OL_FILTER_MS * CLOCK_HZ + 999) / 1000;
   localparam int STARTUP_US = 100;
   localparam int STARTUP_CYCLES =
      (STARTUP_US * CLOCK_HZ + 999_999) / 1_000_000;
   localparam int RETRY_TICK_US = 50;
   localparam int RETRY_TICK_CYCLES =
      (RETRY_TICK_US * CLOCK_HZ + 999_999) / 1_000_000;
   localparam logic [2:0] RETRY_OFF_LONG = 3'h7;
   localparam logic [2:0] RETRY_OFF_SHORT = 3'h1;

   typedef struct packed {
      logic ol_ignore;
      logic duty_high;
      logic [OUTPUT_N-1:0] retry_en;
      logic [OUTPUT_N-1:0] gate_en;
   } ctrl_one_t;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_SETTLE = 2'b01,
      ST_READY = 2'b10
   } startup_t;

   // output served by a driver
   function automatic logic [2:0] drv_output(input int d);
      case (d)
         0, 1: drv_output = 3'h0;
         2, 3: drv_output = 3'h1;
         4, 5: drv_output = 3'h2;
         6: drv_output = 3'h3;
         default: drv_output = 3'h4;
      endcase
   endfunction
endpackage

// ---- dv/spi_host_model.sv ----
// Purpose: host model that writes and reads frames on the serial link
// Assumes: mode 0, msb first, link clock period 32 ns
// Notes: link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // system clock for frame spacing
   input wire logic i_clock,
   // serial link
   output logic o_spi_clock,
   output logic o_spi_cs_n,
   output logic o_spi_mosi,
   input wire logic i_spi_miso
);
   initial begin
      o_spi_clock = 1'b0;
      o_spi_cs_n = 1'b1;
      o_spi_mosi = 1'b0;
   end

   // ***********************************************************
   // one full frame, response sampled on rising link edges
   // ***********************************************************
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      o_spi_cs_n = 1'b0;
      repeat (4) @(posedge i_clock);
      #7;
      for (int i = 15; i >= 0; i--) begin
         o_spi_mosi = w[i];
         #16 o_spi_clock = 1'b1;
         r[i] = i_spi_miso;
         #16 o_spi_clock = 1'b0;
      end
      #16 o_spi_cs_n = 1'b1;
      // released line shows no stale value
      o_spi_mosi = ~o_spi_mosi;
      repeat (6) @(posedge i_clock);
      #2;
   endtask
endmodule
`default_nettype wire

// ---- dv/test_driver_control_status_one.sv ----
// Purpose: self-checking bench for the second control/status word block
// Assumes: shortened filter, settle and retry tick parameters
// Notes: host model drives the link; bench drives the device side
`timescale 1ns/1ps
`default_nettype none
module test_driver_control_status_one;
   import drv_ctrl_one_pkg::*;
   localparam int OLF = 20;
   localparam int SU = 8;
   localparam int TICK = 4;
   logic clock, rst_n, sclk, cs_n, mosi, miso, miso_oe;
   logic active, pulse, fclr, not_ready, fvalid;
   logic [DRIVER_N-1:0] oc, low, onr, drive, ocf, openf;
   logic [6:0] up0;
   logic [3:0] up1;
   ctrl_one_t ctrl;
   logic [WORD_W-1:0] fword, resp;
   int miscompares, total_checks, n, frames;

   driver_control_status_one #(.OL_FILTER(OLF), .STARTUP(SU),
      .RETRY_TICK(TICK)) uut (.i_clock(clock), .i_rst_n(rst_n),
      .i_spi_clock(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
      .o_spi_miso_o(miso), .o_spi_miso_oe(miso_oe), .i_active(active),
      .i_pulse(pulse), .i_overcurrent(oc), .i_low_current(low),
      .i_on_request(onr), .i_fault_clear(fclr),
      .i_status_zero_upper(up0), .i_status_one_upper(up1),
      .o_drive(drive), .o_overcurrent_flag(ocf), .o_open_flag(openf),
      .o_not_ready(not_ready), .o_control(ctrl), .o_frame_valid(fvalid),
      .o_frame_word(fword));

   spi_host_model host (.i_clock(clock), .o_spi_clock(sclk),
      .o_spi_cs_n(cs_n), .o_spi_mosi(mosi), .i_spi_miso(miso));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // one strobe per received frame
   always @(posedge clock) begin
      if (fvalid === 1'b1) begin
         frames++;
      end
   end

   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      #2;
   endtask

   task automatic chk(input logic [15:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   function automatic logic [15:0] ctl(input logic [15:0] w);
      return {4'h0, w[14], w[13], w[10:6], w[5:1]};
   endfunction

   // trip a driver briefly, return cycles until it drives again
   task automatic trip(input int d, output int t);
      oc[d] = 1'b1;
      cyc(3);
      oc[d] = 1'b0;
      cyc(2);
      chk({drive[d], ocf[d]}, 16'h1, "trip off and flag");
      t = 5;
      while (drive[d] !== 1'b1 && t < 100) begin
         cyc(1);
         t++;
      end
   endtask

   task automatic results;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #500_000;
      miscompares++;
      results();
   end

   // ***********************************************************
   // tests
   // ***********************************************************
   initial begin
      miscompares = 0;
      total_checks = 0;
      frames = 0;
      rst_n = 1'b0;
      active = 1'b0;
      pulse = 1'b0;
      fclr = 1'b0;
      oc = '0;
      low = '0;
      onr = 8'h01;
      up0 = '0;
      up1 = '0;
      cyc(4);
      rst_n = 1'b1;
      cyc(3);
      active = 1'b1;
      cyc(1);
      chk(not_ready, 16'h1, "settle set");
      cyc(SU - 1);
      chk({not_ready, drive[0]}, 16'h2, "held off");
      cyc(1);
      chk(not_ready, 16'h0, "settle clear");
      cyc(2);
      chk(drive, 16'h1, "drive after settle");
      chk(miso_oe, 16'h0, "link released");
      $display("test startup done");

      host.xfer(16'h2083, resp);
      chk(fword, 16'h2083, "frame word");
      chk(16'(frames), 16'h1, "frame strobe");
      chk(ctrl, ctl(16'h2083), "control");
      host.xfer(16'h7ffe, resp);
      chk(ctrl, ctl(16'h2083), "control kept");
      host.xfer(16'h2083, resp);
      chk(resp, 16'h0001, "status zero");
      host.xfer(16'h2083, resp);
      chk(resp, 16'h8001, "status one");
      $display("test control word done");

      pulse = 1'b1;
      cyc(4);
      chk(drive[0], 16'h1, "gated on");
      pulse = 1'b0;
      cyc(4);
      chk(drive[0], 16'h0, "gated off");
      onr = 8'h00;
      pulse = 1'b1;
      cyc(4);
      chk(drive[0], 16'h0, "gated needs enable");
      $display("test gating done");

      onr = 8'h04;
      cyc(4);
      trip(2, n);
      chk(16'(n >= 5 && n <= 16), 16'h1, "short retry");
      chk(ocf[2], 16'h1, "flag after retry");
      host.xfer(16'h0081, resp);
      trip(2, n);
      chk(16'(n >= 28 && n <= 40), 16'h1, "long retry");
      host.xfer(16'h0001, resp);
      trip(2, n);
      fclr = 1'b1;
      cyc(1);
      fclr = 1'b0;
      cyc(4);
      chk({drive[2], ocf[2]}, 16'h2, "cleared trip");
      $display("test retry done");

      onr = 8'h01;
      cyc(3);
      low[0] = 1'b1;
      cyc(OLF - 3);
      low[0] = 1'b0;
      cyc(4);
      chk(openf, 16'h0, "filter not met");
      low[0] = 1'b1;
      cyc(OLF + 4);
      chk(openf, 16'h1, "open flag");
      // brief test activation only
      onr = 8'h00;
      low = '0;
      host.xfer(16'h2083, resp);
      chk(resp, 16'h8002, "open in status");
      host.xfer(16'h6083, resp);
      host.xfer(16'h6083, resp);
      chk(resp, 16'h8003, "open ignored");
      up1 = 4'h2;
      host.xfer(16'h6083, resp);
      chk(resp, 16'h9002, "upper bits");
      up1 = 4'h0;
      up0 = 7'h01;
      host.xfer(16'h0000, resp);
      host.xfer(16'h0000, resp);
      chk(resp, 16'h0200, "word zero bits");
      $display("test open load done");
      results();
   end
endmodule
`default_nettype wire

// ---- hw/driver_control_status_one.sv ----
// Purpose: second control word, retry, gating, start-up and open-load flags
// Assumes: serial frames of 16 bits, msb first, chip select low
// Notes: response is chosen by the select bit of the previous frame
//
// What this block does
// RULE_01: retry-enabled output is re-enabled by itself after an off delay
// RULE_02: control bit 13 selects the retry off time, hence duty cycle
// RULE_03: trip at the retry clock phase edge still earns one retry
// RULE_04: gated output follows the pulse input when enabled in this control word
// RULE_05: standby to active sets not-ready and starts the settle timer
// RULE_06: not-ready clears by itself when the settle time has elapsed
// RULE_07: settle time is counted on the system clock only
// RULE_08: current watched only in activated drivers; flags in bits 8..1
// RULE_09: open-circuit flag only after 1 ms of continuous low current
// RULE_10: host keeps test activations short, about 3 ms
// RULE_11: fault-free bit is NOR of bits 1 to 14 of both words
// RULE_12: ignore bit 14 drops open-circuit flags from the fault-free bit
// RULE_13: overcurrent sets the flag and switches the driver off
// RULE_14: without retry the host clears the flag with the reset bit
// RULE_15: frame bit 0 set writes this control word and selects its status
// RULE_16: bit 9 of status word one always reads as zero
`timescale 1ns/1ps
`default_nettype none
module driver_control_status_one
   import drv_ctrl_one_pkg::*;
#(
   parameter int OL_FILTER = OL_FILTER_CYCLES,
   parameter int STARTUP = STARTUP_CYCLES,
   parameter int RETRY_TICK = RETRY_TICK_CYCLES
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // serial link
   input wire logic i_spi_clock,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_mosi,
   output logic o_spi_miso_o,
   output logic o_spi_miso_oe,
   // device side
   input wire logic i_active,
   input wire logic i_pulse,
   input wire logic [DRIVER_N-1:0] i_overcurrent,
   input wire logic [DRIVER_N-1:0] i_low_current,
   input wire logic [DRIVER_N-1:0] i_on_request,
   input wire logic i_fault_clear,
   input wire logic [6:0] i_status_zero_upper,
   input wire logic [3:0] i_status_one_upper,
   // results
   output logic [DRIVER_N-1:0] o_drive,
   output logic [DRIVER_N-1:0] o_overcurrent_flag,
   output logic [DRIVER_N-1:0] o_open_flag,
   output logic o_not_ready,
   output ctrl_one_t o_control,
   output logic o_frame_valid,
   output logic [WORD_W-1:0] o_frame_word
);
   localparam int OW = $clog2(OL_FILTER + 1);
   localparam int SW = $clog2(STARTUP + 1);
   localparam int TW = $clog2(RETRY_TICK + 1);

   // ***********************************************************
   // link domain
   // ***********************************************************
   logic [3:0] bit_count;
   logic [WORD_W-1:0] shift_in;
   logic [WORD_W-1:0] rx_word;
   logic rx_toggle;
   logic miso_q;
   logic miso_started;
   logic [WORD_W-1:0] tx_hold;

   always_ff @(posedge i_spi_clock or posedge i_spi_cs_n) begin
      if (i_spi_cs_n) begin
         bit_count <= 4'h0;
         shift_in <= 16'h0000;
      end else begin
         shift_in <= {shift_in[14:0], i_spi_mosi};
         bit_count <= bit_count + 4'h1;
      end
   end

   always_ff @(posedge i_spi_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_word <= 16'h0000;
         rx_toggle <= 1'b0;
      end else if (!i_spi_cs_n && bit_count == 4'hf) begin
         rx_word <= {shift_in[14:0], i_spi_mosi};
         rx_toggle <= ~rx_toggle;
      end
   end

   // tx_hold only changes while the synchronised chip select is high
   always_ff @(negedge i_spi_clock or posedge i_spi_cs_n) begin
      if (i_spi_cs_n) begin
         miso_q <= 1'b0;
         miso_started <= 1'b0;
      end else begin
         miso_q <= tx_hold[4'hf - bit_count];
         miso_started <= 1'b1;
      end
   end

   assign o_spi_miso_o = miso_started ? miso_q : tx_hold[ALWAYS_ONE_BIT];
   assign o_spi_miso_oe = ~i_spi_cs_n;

   // ***********************************************************
   // crossings and pin synchronisers
   // ***********************************************************
   logic cs_meta, cs_sync, tog_meta, tog_sync, tog_seen;
   logic pulse_meta, pulse_s;
   logic [DRIVER_N-1:0] oc_meta, oc_s, low_meta, low_s;
   logic frame_event;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         tog_seen <= 1'b0;
         pulse_meta <= 1'b0;
         pulse_s <= 1'b0;
         oc_meta <= '0;
         oc_s <= '0;
         low_meta <= '0;
         low_s <= '0;
      end else begin
         cs_meta <= i_spi_cs_n;
         cs_sync <= cs_meta;
         tog_meta <= rx_toggle;
         tog_sync <= tog_meta;
         tog_seen <= tog_sync;
         pulse_meta <= i_pulse;
         pulse_s <= pulse_meta;
         oc_meta <= i_overcurrent;
         oc_s <= oc_meta;
         low_meta <= i_low_current;
         low_s <= low_meta;
      end
   end

   assign frame_event = tog_sync ^ tog_seen;

   // ***********************************************************
   // control word and frame hand-off
   // ***********************************************************
   logic word_sel;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_control <= ctrl_one_t'({CTRL_RESET[OL_IGNORE_BIT],
            CTRL_RESET[DUTY_BIT], CTRL_RESET[RETRY_LO +: OUTPUT_N],
            CTRL_RESET[GATE_LO +: OUTPUT_N]});
         word_sel <= 1'b0;
         o_frame_valid <= 1'b0;
         o_frame_word <= 16'h0000;
      end else begin
         o_frame_valid <= frame_event;
         if (frame_event) begin
            o_frame_word <= rx_word;
            word_sel <= rx_word[SEL_BIT]; // [RULE_15]
            if (rx_word[SEL_BIT]) begin
               o_control.ol_ignore <= rx_word[OL_IGNORE_BIT];
               o_control.duty_high <= rx_word[DUTY_BIT];
               o_control.retry_en <= rx_word[RETRY_LO +: OUTPUT_N];
               o_control.gate_en <= rx_word[GATE_LO +: OUTPUT_N];
            end
         end
      end
   end

   // ***********************************************************
   // start-up timer
   // ***********************************************************
   startup_t state;
   logic active_q;
   logic [SW-1:0] settle_cnt;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_STANDBY;
         active_q <= 1'b0;
         settle_cnt <= '0;
      end else begin
         active_q <= i_active;
         case (state)
            ST_STANDBY: begin
               settle_cnt <= '0;
               if (i_active && !active_q) begin
                  state <= ST_SETTLE; // [RULE_05]
               end
            end
            ST_SETTLE: begin
               settle_cnt <= settle_cnt + SW'(1); // [RULE_07]
               if (!i_active) begin
                  state <= ST_STANDBY;
               end else if (settle_cnt == SW'(STARTUP - 1)) begin
                  state <= ST_READY; // [RULE_06]
               end
            end
            ST_READY: begin
               if (!i_active) begin
                  state <= ST_STANDBY;
               end
            end
            default: state <= ST_STANDBY;
         endcase
      end
   end

   assign o_not_ready = (state == ST_SETTLE); // [RULE_05]

   // ***********************************************************
   // overcurrent trip and automatic retry
   // ***********************************************************
   logic [TW-1:0] phase;
   logic tick, phase_edge;
   logic [DRIVER_N-1:0] tripped, grace, trip;
   logic [2:0] wait_cnt [DRIVER_N];
   logic [2:0] off_ticks;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase <= '0;
      end else if (tick) begin
         phase <= '0;
      end else begin
         phase <= phase + TW'(1);
      end
   end

   assign tick = (phase == TW'(RETRY_TICK - 1));
   assign phase_edge = tick;
   assign off_ticks = o_control.duty_high ? RETRY_OFF_SHORT
                                          : RETRY_OFF_LONG; // [RULE_02]
   assign trip = oc_s & o_drive;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tripped <= '0;
         grace <= '0;
         o_overcurrent_flag <= '0;
         for (int d = 0; d < DRIVER_N; d++) begin
            wait_cnt[d] <= 3'h0;
         end
      end else begin
         for (int d = 0; d < DRIVER_N; d++) begin
            if (trip[d]) begin
               tripped[d] <= 1'b1; // [RULE_13]
               o_overcurrent_flag[d] <= 1'b1;
               grace[d] <= phase_edge; // [RULE_03]
               wait_cnt[d] <= off_ticks;
            end else if (i_fault_clear) begin
               tripped[d] <= 1'b0; // [RULE_14]
               o_overcurrent_flag[d] <= 1'b0;
               grace[d] <= 1'b0;
            end else if (tripped[d] && tick &&
                  (o_control.retry_en[drv_output(d)] || grace[d])) begin
               if (wait_cnt[d] == 3'h0) begin
                  tripped[d] <= 1'b0; // [RULE_01]
                  grace[d] <= 1'b0;
               end else begin
                  wait_cnt[d] <= wait_cnt[d] - 3'h1;
               end
            end
         end
      end
   end

   // ***********************************************************
   // output drive with pulse gating
   // ***********************************************************
   logic [DRIVER_N-1:0] next_drive;

   always_comb begin
      for (int d = 0; d < DRIVER_N; d++) begin
         next_drive[d] = i_on_request[d] && !tripped[d] &&
            (state == ST_READY) &&
            (!o_control.gate_en[drv_output(d)] || pulse_s); // [RULE_04]
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_drive <= '0;
      end else begin
         o_drive <= next_drive;
      end
   end

   // ***********************************************************
   // open-circuit filter
   // ***********************************************************
   logic [OW-1:0] ol_cnt [DRIVER_N];

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_open_flag <= '0;
         for (int d = 0; d < DRIVER_N; d++) begin
            ol_cnt[d] <= '0;
         end
      end else begin
         for (int d = 0; d < DRIVER_N; d++) begin
            if (o_drive[d] && low_s[d]) begin // [RULE_08]
               if (ol_cnt[d] == OW'(OL_FILTER - 1)) begin
                  o_open_flag[d] <= 1'b1; // [RULE_09]
               end else begin
                  ol_cnt[d] <= ol_cnt[d] + OW'(1);
               end
            end else begin
               ol_cnt[d] <= '0;
            end
            if (i_fault_clear && !(o_drive[d] && low_s[d] &&
                  ol_cnt[d] == OW'(OL_FILTER - 1))) begin
               o_open_flag[d] <= 1'b0;
            end
         end
      end
   end

   // ***********************************************************
   // status words
   // ***********************************************************
   logic no_error;
   logic [WORD_W-1:0] status_zero, status_one;

   assign no_error = ~(|i_status_zero_upper[5:0] | |o_overcurrent_flag |
      |i_status_one_upper | o_not_ready |
      (~o_control.ol_ignore & |o_open_flag)); // [RULE_11] [RULE_12]
   assign status_zero = {i_status_zero_upper, o_overcurrent_flag, no_error};
   assign status_one = {1'b1, i_status_one_upper, o_not_ready,
      1'b0, o_open_flag, no_error}; // [RULE_16]

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_hold <= 16'h8000;
      end else if (cs_sync) begin
         tx_hold <= word_sel ? status_one : status_zero;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   logic [SW:0] nr_len;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nr_len <= '0;
      end else if (o_not_ready) begin
         nr_len <= nr_len + (SW+1)'(1);
      end else begin
         nr_len <= '0;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   // retry checks watch driver 2, output_two low, retry enable of output two
   sequence seq_trip2;
      trip[2] && !i_fault_clear;
   endsequence
   sequence seq_release2;
      tripped[2] && tick && wait_cnt[2] == 3'h0 && !trip[2] &&
         !i_fault_clear && o_control.retry_en[1];
   endsequence

   a_retry_release: assert property (seq_release2 |=> !tripped[2]) // RULE_01
      else $error("retry did not release driver");
   a_duty_reload: assert property (seq_trip2 |=> // RULE_02
      wait_cnt[2] == ($past(o_control.duty_high) ? 3'h1 : 3'h7))
      else $error("retry off time wrong");
   a_grace_retry: assert property (seq_trip2 ##0 tick |=> grace[2]) // RULE_03
      else $error("phase edge trip lost its retry");
   a_gate_follow: assert property ( // RULE_04
      o_control.gate_en[0] && !pulse_s |=> !o_drive[0])
      else $error("gated output on while pulse low");
   a_startup_set: assert property ( // RULE_05
      state == ST_STANDBY && i_active && !active_q |=> o_not_ready)
      else $error("not-ready not set on wake");
   a_startup_len: assert property ( // RULE_06
      $fell(o_not_ready) && i_active |-> nr_len == (SW+1)'(STARTUP))
      else $error("settle time wrong");
   a_startup_gate: assert property (o_not_ready |=> o_drive == '0) // RULE_07
      else $error("output active during settle");
   a_ol_filter: assert property ($rose(o_open_flag[0]) |-> // RULE_09
      $past(ol_cnt[0]) == OW'(OL_FILTER - 1))
      else $error("open flag set before filter time");
   a_ol_idle: assert property (!o_drive[0] |=> ol_cnt[0] == '0) // RULE_08
      else $error("open filter ran on idle driver");
   a_no_error: assert property ( // RULE_11
      o_overcurrent_flag != '0 |-> !status_one[NO_ERROR_BIT])
      else $error("fault-free bit set with a fault");
   a_ol_ignore: assert property (o_control.ol_ignore && // RULE_12
      o_overcurrent_flag == '0 && !o_not_ready && i_status_one_upper == '0
      && i_status_zero_upper[5:0] == '0 |-> no_error)
      else $error("open flags not ignored");
   a_trip_off: assert property (seq_trip2 |=> // RULE_13
      o_overcurrent_flag[2] ##1 !o_drive[2])
      else $error("tripped driver stayed on");
   a_select_write: assert property (frame_event && rx_word[0] |=> // RULE_15
      o_control.retry_en == $past(rx_word[10:6]) && word_sel)
      else $error("control word not written");
   a_bit9_zero: assert property (cs_sync && word_sel |=> // RULE_16
      !tx_hold[UNUSED_BIT])
      else $error("unused status bit not zero");
endmodule
`default_nettype wire
